// >>> rtl/scss_pkg.sv
// Package for the system clock source selector: map, fields, codes, timing and state
// What this block does
// RULE1 - After every reset the start-up clock source comes from the reset clock choice field.
// RULE2 - The reset choice can pick the slow oscillator, the fast one at 1 MHz or the fast one at 32 MHz.
// RULE3 - With an external source the three-bit kind field picks one of three logic-clock or three crystal modes.
// RULE4 - The outside clock stays at or under 500 kHz, 8 MHz and 32 MHz in the low, medium and high power modes.
// RULE5 - Logic-clock modes take a logic-level clock while crystal modes have a crystal or resonator attached.
// RULE6 - The crystal modes serve 32 kHz parts, parts from 100 kHz to 4 MHz, and parts above 4 MHz.
// RULE7 - The fail-safe monitor sees a dead outside clock and moves the system clock to the fast oscillator.
// RULE8 - The start-up timer holds a crystal source off until it has run long enough to be stable.
// RULE9 - Software asks for a new source and divider through a three-bit and a four-bit field.
// RULE10 - Outside crystal modes the clock-out pin shows the oscillator rate divided by four.
// RULE11 - Crystal modes drive the crystal from the drive pin and sense it on the crystal input; others use the clock pin.
// RULE12 - A slow and a fast internal oscillator feed every internally derived system rate.
// RULE13 - A request completes once its source is ready, updating current source, divider and both ready flags.
// RULE14 - The fail-safe monitor runs only when enabled, and requests are taken only when switching is allowed.
package scss_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_NEW_SRC  = 12'h88D;
    localparam logic [11:0] IDX_CUR_SRC  = 12'h88E;
    localparam logic [11:0] IDX_SW_CTL   = 12'h88F;
    localparam logic [11:0] IDX_RDY      = 12'h890;
    localparam logic [11:0] IDX_FORCE    = 12'h891;
    localparam logic [11:0] IDX_TUNE     = 12'h892;
    localparam logic [11:0] IDX_FRQ      = 12'h893;
    localparam logic [11:0] IDX_RCON     = 12'h895;
    localparam logic [11:0] IDX_RCLK     = 12'h896;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h8A0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h8A1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions, write masks and reset values
    localparam int         SRC_LSB    = 4;
    localparam int         HOLD_BIT   = 7;
    localparam int         SWITCH_READY_FLAG_BIT   = 4;
    localparam int         NEW_SOURCE_READY_FLAG_BIT  = 3;
    localparam int         EXTR_BIT   = 7;
    localparam int         FASTR_BIT  = 6;
    localparam int         SLOWR_BIT  = 4;
    localparam int         IRQ_SW     = 0;
    localparam int         IRQ_FAIL   = 1;
    localparam logic [7:0] FORCE_MASK = 8'hFC;
    localparam logic [7:0] TUNE_MASK  = 8'h3F;
    localparam logic [7:0] FRQ_MASK   = 8'h07;
    localparam logic [7:0] RCON_MASK  = 8'h9F;
    localparam logic [7:0] RCLK_MASK  = 8'h0F;
    localparam logic [7:0] TUNE_RST   = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Source, reset choice, divider and external kind codes
    localparam logic [2:0] SRC_SLOW   = 3'h5;
    localparam logic [2:0] SRC_FAST   = 3'h6;
    localparam logic [2:0] SRC_EXT    = 3'h7;
    localparam logic [2:0] CH_FAST32  = 3'h0;
    localparam logic [2:0] CH_FAST1M  = 3'h6;
    localparam logic [2:0] CH_SLOW    = 3'h5;
    localparam logic [2:0] CH_EXT     = 3'h7;
    localparam logic [3:0] DIV_1      = 4'h0;
    localparam logic [3:0] DIV_1M     = 4'h5;
    localparam logic [3:0] DIV_MAX    = 4'h9;
    localparam logic [2:0] EK_LP      = 3'h4;
    localparam logic [2:0] EK_XT      = 3'h5;
    localparam logic [2:0] EK_HS      = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: monitor timeout and start-up edge count
    localparam int CLK_PERIOD_NS = 25;
    localparam int FAIL_TIME_NS  = 10000;
    localparam int FAIL_CYCLES   = (FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OST_EDGES     = 1024;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_SWITCH} scss_sw_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [13:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } scss_wb_req_s;

    typedef struct packed {
        logic [2:0]  sy_ext;
        logic [2:0]  sy_xin;
        logic [2:0]  sy_slow;
        logic [2:0]  sy_fast;
        logic [2:0]  choice;
        logic [2:0]  kind;
        logic        fs_en;
        logic        sw_allow;
        logic [2:0]  new_src;
        logic [3:0]  new_div;
        logic [2:0]  cur_src;
        logic [3:0]  cur_div;
        logic        hold;
        logic        switch_ready_flag;
        logic        new_source_ready_flag;
        scss_sw_e    sw;
        logic [7:0]  force_en;
        logic [7:0]  tune;
        logic [7:0]  frq;
        logic [7:0]  rcon;
        logic [7:0]  rclk;
        logic        ext_rdy;
        logic        slow_rdy;
        logic        fast_rdy;
        logic [10:0] ost_cnt;
        logic [11:0] mon_cnt;
        logic [9:0]  div_cnt;
        logic [1:0]  q_cnt;
        logic        tick;
        logic        xdrv;
        logic [1:0]  irq_st;
        logic [1:0]  irq_mask;
        logic        ack;
        logic [31:0] dat;
    } scss_state_s;

    // Crystal modes of the external kind field
    function automatic logic is_crystal(input logic [2:0] k);
        return (k == EK_LP) || (k == EK_XT) || (k == EK_HS);
    endfunction

    // Start-up source for a reset choice
    function automatic logic [2:0] rst_src(input logic [2:0] c);
        if (c == CH_SLOW)
            return SRC_SLOW;
        else if (c == CH_EXT)
            return SRC_EXT;
        return SRC_FAST;
    endfunction

    // Start-up divider for a reset choice
    function automatic logic [3:0] rst_div(input logic [2:0] c);
        return (c == CH_FAST1M) ? DIV_1M : DIV_1;
    endfunction

endpackage

// >>> rtl/scss_top.sv
// System clock source selector with fail-safe monitor, start-up timer and Wishbone registers
module scss_top #(
    parameter int OST_EDGES   = scss_pkg::OST_EDGES,
    parameter int FAIL_CYCLES = scss_pkg::FAIL_CYCLES
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Configuration word bits
    input  wire logic [2:0]             reset_clock_choice_i,
    input  wire logic [2:0]             external_clock_kind_i,
    input  wire logic                   failsafe_enable_i,
    input  wire logic                   switch_allow_i,
    // Internal oscillator block outputs
    input  wire logic                   slow_internal_osc_i,
    input  wire logic                   fast_internal_osc_i,
    // Clock pins
    input  wire logic                   ext_clock_in_pin_i,
    input  wire logic                   crystal_in_pin_i,
    output logic                        crystal_drive_pin_o,
    output logic                        crystal_drive_pin_oe_o,
    output logic                        quarter_clock_out_pin_o,
    output logic                        quarter_clock_out_pin_oe_o,
    // System clock enable and interrupt
    output logic                        sys_clk_en_o,
    output logic                        irq_o,
    // Wishbone slave
    input  wire scss_pkg::scss_wb_req_s wb_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State and decode helpers
    localparam logic [10:0] OST_LIM  = 11'(OST_EDGES);
    localparam logic [11:0] FAIL_LIM = 12'(FAIL_CYCLES);

    scss_pkg::scss_state_s r;
    scss_pkg::scss_state_s n;
    logic                  xtal;
    logic                  ext_edge;
    logic                  src_edge;
    logic                  fail_evt;
    logic                  rdy_sel;
    logic                  bus_req;
    logic                  wr;
    logic                  wr_nsc;
    logic [11:0]           idx;
    logic [9:0]            lim;
    logic [3:0]            dv;
    logic [1:0]            irq_set;
    logic [7:0]            wd;
    logic [7:0]            rd;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        n        = r;
        n.ack    = 1'b0;
        n.tick   = 1'b0;
        fail_evt = 1'b0;
        irq_set  = 2'h0;
        rd       = 8'h00;
        xtal     = scss_pkg::is_crystal(r.kind);
        idx      = wb_i.adr[13:2];
        wd       = wb_i.dat[7:0];
        bus_req  = wb_i.cyc && wb_i.stb && !r.ack;
        wr       = bus_req && wb_i.we && wb_i.sel[0];
        wr_nsc   = wr && (idx == scss_pkg::IDX_NEW_SRC);

        // Two-stage synchronisers, third stage remembers the last level
        n.sy_ext  = {r.sy_ext[1:0], ext_clock_in_pin_i};
        n.sy_xin  = {r.sy_xin[1:0], crystal_in_pin_i};
        n.sy_slow = {r.sy_slow[1:0], slow_internal_osc_i};
        n.sy_fast = {r.sy_fast[1:0], fast_internal_osc_i};

        // Crystal modes sense the crystal input, logic modes the clock pin
        if (xtal)                                                       // [RULE11] [RULE3] [RULE5]
            ext_edge = r.sy_xin[1] && !r.sy_xin[2];
        else
            ext_edge = r.sy_ext[1] && !r.sy_ext[2];

        // Crystal drive follows the inverted sensed level
        n.xdrv = xtal && !r.sy_xin[1];                                   // [RULE11]

        // Internal oscillators are ready once they have toggled
        if (r.sy_slow[1] && !r.sy_slow[2])                               // [RULE12]
            n.slow_rdy = 1'b1;
        if (r.sy_fast[1] && !r.sy_fast[2])                               // [RULE12]
            n.fast_rdy = 1'b1;

        // Start-up timer and loss-of-clock monitor
        if (ext_edge)
        begin
            n.mon_cnt = 12'h000;
            if (!xtal)
                n.ext_rdy = 1'b1;
            else if (r.ost_cnt != OST_LIM)                               // [RULE8]
                n.ost_cnt = r.ost_cnt + 11'h001;
            else
                n.ext_rdy = 1'b1;
        end
        else if (r.mon_cnt != FAIL_LIM)
        begin
            n.mon_cnt = r.mon_cnt + 12'h001;
        end
        else
        begin
            n.ext_rdy = 1'b0;
            n.ost_cnt = 11'h000;                                         // [RULE8]
            fail_evt  = r.fs_en && (r.ext_rdy || r.cur_src == scss_pkg::SRC_EXT); // [RULE7] [RULE14]
        end

        // Edge of the running source; external counts only once ready
        if (r.cur_src == scss_pkg::SRC_SLOW)
            src_edge = r.sy_slow[1] && !r.sy_slow[2];                    // [RULE12]
        else if (r.cur_src == scss_pkg::SRC_EXT)
            src_edge = ext_edge && r.ext_rdy;                            // [RULE8]
        else
            src_edge = r.sy_fast[1] && !r.sy_fast[2];                    // [RULE12]

        // Divider by a power of two, then Fosc/4 counter
        dv  = (r.cur_div > scss_pkg::DIV_MAX) ? scss_pkg::DIV_MAX : r.cur_div;
        lim = ~(10'h3FF << dv);
        if (src_edge)
        begin
            if (r.div_cnt >= lim)
            begin
                n.div_cnt = 10'h000;
                n.tick    = 1'b1;
                n.q_cnt   = r.q_cnt + 2'h1;                              // [RULE10]
            end
            else
            begin
                n.div_cnt = r.div_cnt + 10'h001;
            end
        end

        // Readiness of the requested source
        if (r.new_src == scss_pkg::SRC_SLOW)
            rdy_sel = r.slow_rdy;
        else if (r.new_src == scss_pkg::SRC_EXT)
            rdy_sel = r.ext_rdy;
        else
            rdy_sel = r.fast_rdy;

        // Switch sequence
        case (r.sw)
            scss_pkg::SW_IDLE:
            begin
                n.sw = scss_pkg::SW_IDLE;
            end
            scss_pkg::SW_WAIT:
            begin
                if (rdy_sel)                                             // [RULE13]
                begin
                    n.new_source_ready_flag = 1'b1;
                    if (!r.hold)
                        n.sw = scss_pkg::SW_SWITCH;
                end
            end
            scss_pkg::SW_SWITCH:
            begin
                n.cur_src          = r.new_src;                          // [RULE13]
                n.cur_div          = r.new_div;
                n.switch_ready_flag             = 1'b1;
                n.div_cnt          = 10'h000;
                n.sw               = scss_pkg::SW_IDLE;
                irq_set[scss_pkg::IRQ_SW] = 1'b1;
            end
            default:
            begin
                n.sw = scss_pkg::SW_IDLE;
            end
        endcase

        // A new request restarts the sequence when switching is allowed
        if (wr_nsc && r.sw_allow)                                        // [RULE9] [RULE14]
        begin
            n.sw    = scss_pkg::SW_WAIT;
            n.new_source_ready_flag = 1'b0;
            n.switch_ready_flag  = 1'b0;
        end

        // Fail-safe takes over last so it wins over a switch
        if (fail_evt)
        begin
            irq_set[scss_pkg::IRQ_FAIL] = 1'b1;
            if (n.cur_src == scss_pkg::SRC_EXT)
            begin
                n.cur_src = scss_pkg::SRC_FAST;                          // [RULE7]
                n.div_cnt = 10'h000;
            end
        end

        // Register writes
        if (wr)
        begin
            if (idx == scss_pkg::IDX_NEW_SRC)
            begin
                n.new_src = wd[scss_pkg::SRC_LSB +: 3];                  // [RULE9]
                n.new_div = wd[3:0];
            end
            else if (idx == scss_pkg::IDX_SW_CTL)
                n.hold = wd[scss_pkg::HOLD_BIT];
            else if (idx == scss_pkg::IDX_FORCE)
                n.force_en = wd & scss_pkg::FORCE_MASK;
            else if (idx == scss_pkg::IDX_TUNE)
                n.tune = wd & scss_pkg::TUNE_MASK;
            else if (idx == scss_pkg::IDX_FRQ)
                n.frq = wd & scss_pkg::FRQ_MASK;
            else if (idx == scss_pkg::IDX_RCON)
                n.rcon = wd & scss_pkg::RCON_MASK;
            else if (idx == scss_pkg::IDX_RCLK)
                n.rclk = wd & scss_pkg::RCLK_MASK;
            else if (idx == scss_pkg::IDX_IRQ_MASK)
                n.irq_mask = wd[1:0];
        end

        // Sticky events, write one to clear, a new event wins
        if (wr && idx == scss_pkg::IDX_IRQ_STAT)
            n.irq_st = (r.irq_st & ~wd[1:0]) | irq_set;
        else
            n.irq_st = r.irq_st | irq_set;

        // Register reads, unmapped words read zero
        if (idx == scss_pkg::IDX_NEW_SRC)
            rd = {1'b0, r.new_src, r.new_div};
        else if (idx == scss_pkg::IDX_CUR_SRC)
            rd = {1'b0, r.cur_src, r.cur_div};                           // [RULE13]
        else if (idx == scss_pkg::IDX_SW_CTL)
        begin
            rd[scss_pkg::HOLD_BIT]  = r.hold;
            rd[scss_pkg::SWITCH_READY_FLAG_BIT]  = r.switch_ready_flag;
            rd[scss_pkg::NEW_SOURCE_READY_FLAG_BIT] = r.new_source_ready_flag;
        end
        else if (idx == scss_pkg::IDX_RDY)
        begin
            rd[scss_pkg::EXTR_BIT]  = r.ext_rdy;
            rd[scss_pkg::FASTR_BIT] = r.fast_rdy;
            rd[scss_pkg::SLOWR_BIT] = r.slow_rdy;
        end
        else if (idx == scss_pkg::IDX_FORCE)
            rd = r.force_en;
        else if (idx == scss_pkg::IDX_TUNE)
            rd = r.tune;
        else if (idx == scss_pkg::IDX_FRQ)
            rd = r.frq;
        else if (idx == scss_pkg::IDX_RCON)
            rd = r.rcon;
        else if (idx == scss_pkg::IDX_RCLK)
            rd = r.rclk;
        else if (idx == scss_pkg::IDX_IRQ_STAT)
            rd = {6'h00, r.irq_st};
        else if (idx == scss_pkg::IDX_IRQ_MASK)
            rd = {6'h00, r.irq_mask};

        // One-cycle acknowledge with registered data
        if (bus_req)
        begin
            n.ack = 1'b1;
            n.dat = {24'h000000, rd};
        end

        // Synchronous reset; configuration bits caught here
        if (rst_i)
        begin
            n          = '0;
            n.tune     = scss_pkg::TUNE_RST;
            n.sw       = scss_pkg::SW_IDLE;
            n.choice   = reset_clock_choice_i;
            n.kind     = external_clock_kind_i;                          // [RULE3]
            n.fs_en    = failsafe_enable_i;                              // [RULE14]
            n.sw_allow = switch_allow_i;                                 // [RULE14]
            n.cur_src  = scss_pkg::rst_src(reset_clock_choice_i);        // [RULE1] [RULE2]
            n.cur_div  = scss_pkg::rst_div(reset_clock_choice_i);        // [RULE2]
            n.new_src  = scss_pkg::rst_src(reset_clock_choice_i);
            n.new_div  = scss_pkg::rst_div(reset_clock_choice_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i)
    begin
        r <= n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign crystal_drive_pin_o        = r.xdrv;
    assign crystal_drive_pin_oe_o     = scss_pkg::is_crystal(r.kind);   // [RULE11]
    assign quarter_clock_out_pin_o    = r.q_cnt[1] && !scss_pkg::is_crystal(r.kind); // [RULE10]
    assign quarter_clock_out_pin_oe_o = !scss_pkg::is_crystal(r.kind);  // [RULE10]
    assign sys_clk_en_o               = r.tick;
    assign irq_o                      = |(r.irq_st & r.irq_mask);
    assign wb_dat_o                   = r.dat;
    assign wb_ack_o                   = r.ack;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ready;
        r.sw == scss_pkg::SW_WAIT && rdy_sel && !r.hold && !wr_nsc;
    endsequence

    sequence s_clean;
        !wr_nsc && !fail_evt;
    endsequence

    reset_pick_a: assert property ($fell(rst_i) |-> r.cur_src == scss_pkg::rst_src(r.choice)) // [RULE1]
        else $error("start-up source differs from reset choice");

    fast_1m_a: assert property ($fell(rst_i) && r.choice == scss_pkg::CH_FAST1M // [RULE2]
        |-> r.cur_src == scss_pkg::SRC_FAST && r.cur_div == scss_pkg::DIV_1M)
        else $error("1 MHz start-up not set");

    fail_over_a: assert property (fail_evt && r.cur_src == scss_pkg::SRC_EXT // [RULE7]
        |=> r.cur_src == scss_pkg::SRC_FAST && r.irq_st[scss_pkg::IRQ_FAIL])
        else $error("no fail-safe takeover");

    ost_hold_a: assert property (xtal && r.ost_cnt != OST_LIM |-> !r.ext_rdy) // [RULE8]
        else $error("crystal used before start-up count");

    req_take_a: assert property (wr_nsc && r.sw_allow // [RULE9]
        |=> r.sw == scss_pkg::SW_WAIT && r.new_src == $past(wb_i.dat[6:4]) && !r.switch_ready_flag)
        else $error("request not taken");

    quarter_out_a: assert property (!xtal && r.tick && r.q_cnt == 2'h2 // [RULE10]
        |-> $rose(quarter_clock_out_pin_o))
        else $error("clock out not at Fosc/4");

    xtal_drive_a: assert property (xtal |=> crystal_drive_pin_o == !$past(r.sy_xin[1])) // [RULE11]
        else $error("crystal drive wrong");

    switch_done_a: assert property (s_ready ##1 s_clean // [RULE13]
        |=> r.switch_ready_flag && r.new_source_ready_flag && r.cur_src == $past(r.new_src))
        else $error("switch did not complete");

    sw_block_a: assert property (!r.sw_allow |-> r.sw == scss_pkg::SW_IDLE) // [RULE14]
        else $error("request taken while not allowed");

    fs_off_a: assert property (!r.fs_en && r.cur_src == scss_pkg::SRC_EXT // [RULE14]
        && r.sw != scss_pkg::SW_SWITCH |=> r.cur_src == scss_pkg::SRC_EXT)
        else $error("fail-safe acted while disabled");

endmodule

// >>> dv/scss_ext_model.sv
// Outside clock source model: a logic clock or a crystal that needs its drive pin
module scss_ext_model #(
    parameter int HALF = 4
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic xtal_i,
    input  wire logic drive_oe_i,
    output logic      ext_clk_o,
    output logic      xin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cnt = 0;
    logic osc = 1'b0;
    // Oscillates while running; a crystal only swings while the drive pin is enabled
    always @(posedge clk_i)
    begin
        if (run_i && (!xtal_i || drive_oe_i))
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                osc <= ~osc;
        end
    end
    // A stopped source stands still; the unused pin stays low
    assign ext_clk_o = xtal_i ? 1'b0 : osc;
    assign xin_o     = xtal_i ? osc : 1'b0;
endmodule

// >>> dv/system_clock_source_select_bench.sv
// Testbench for the system clock source selector
module system_clock_source_select_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   clk = 0, rst = 1, fs = 1, allow = 1, slow = 0, fast = 0, run = 0, xtal = 0;
    logic [2:0]             choice = scss_pkg::CH_EXT, kind = 3'h0;
    scss_pkg::scss_wb_req_s wb = '0;
    logic                   eclk, xin, drv, drv_oe, qout, qout_oe, tick, irq, ack;
    logic [31:0]            rdat, lfsr = 32'hCFE0;
    logic [7:0]             q[$];
    int                     num_errors = 0, cmp_count = 0, cyc_n = 0, n;

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Internal oscillators, cycle count and hang limit
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        fast  <= cyc_n[2];
        slow  <= cyc_n[4];
        if (cyc_n == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    scss_ext_model #(.HALF(4)) ext (.clk_i(clk), .run_i(run), .xtal_i(xtal), .drive_oe_i(drv_oe),
        .ext_clk_o(eclk), .xin_o(xin));

    scss_top #(.OST_EDGES(4), .FAIL_CYCLES(20)) DUT (.clk_i(clk), .rst_i(rst), .reset_clock_choice_i(choice),
        .external_clock_kind_i(kind), .failsafe_enable_i(fs), .switch_allow_i(allow),
        .slow_internal_osc_i(slow), .fast_internal_osc_i(fast), .ext_clock_in_pin_i(eclk),
        .crystal_in_pin_i(xin), .crystal_drive_pin_o(drv), .crystal_drive_pin_oe_o(drv_oe),
        .quarter_clock_out_pin_o(qout), .quarter_clock_out_pin_oe_o(qout_oe), .sys_clk_en_o(tick),
        .irq_o(irq), .wb_i(wb), .wb_dat_o(rdat), .wb_ack_o(ack));

    ////////////////////////////////////////////////////////////////////////////
    // Read results against the oldest expectation
    always @(posedge clk)
    begin
        if (ack === 1'b1 && wb.we === 1'b0)
        begin
            cmp_count++;
            if (q.size() == 0 || rdat !== {24'h0, q[0]})
            begin
                num_errors++;
                $display("unexpected read data: expected %h seen %h", q.size() ? q[0] : 8'h0, rdat);
            end
            if (q.size() != 0)
                void'(q.pop_front());
        end
    end

    // Pin comparison
    task automatic chk(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb_cyc(input logic [11:0] idx, input logic w, input logic [7:0] d);
        @(posedge clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, d}};
        do @(posedge clk); while (ack !== 1'b1);
        wb <= '0;
    endtask

    task automatic wb_rd(input logic [11:0] idx, input logic [7:0] e);
        q.push_back(e);
        wb_cyc(idx, 1'b0, 8'h00);
    endtask

    // Reset with a configuration word
    task automatic do_reset(input logic [2:0] c, input logic [2:0] k, input logic x, input logic fa);
        @(posedge clk);
        {rst, choice, kind, xtal, fs, allow} <= {1'b1, c, k, x, fa, fa};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wait_irq;
        repeat (300)
        begin
            @(posedge clk);
            if (irq === 1'b1)
                break;
        end
    endtask

    task automatic wrap_up;
        num_errors += q.size(); // Reads that never answered
        $display("compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        do_reset(scss_pkg::CH_EXT, 3'h0, 1'b0, 1'b1);
        chk("quarter_clock_out_pin_oe", 1'b1, qout_oe);
        chk("drive_oe", 1'b0, drv_oe);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_EXT, scss_pkg::DIV_1});
        wb_rd(scss_pkg::IDX_TUNE, scss_pkg::TUNE_RST);
        wb_rd(12'h8A5, 8'h00);
        lfsr = lfsr_next(lfsr);
        wb_cyc(scss_pkg::IDX_TUNE, 1'b1, lfsr[7:0]);
        wb_rd(scss_pkg::IDX_TUNE, lfsr[7:0] & scss_pkg::TUNE_MASK);
        $display("test reset_and_registers done");
        run <= 1'b1;
        repeat (60) @(posedge clk);
        wb_rd(scss_pkg::IDX_RDY, 8'hD0);
        wb_rd(scss_pkg::IDX_IRQ_STAT, 8'h02);
        wb_cyc(scss_pkg::IDX_IRQ_STAT, 1'b1, 8'h03);
        wb_cyc(scss_pkg::IDX_IRQ_MASK, 1'b1, 8'h03);
        wb_cyc(scss_pkg::IDX_NEW_SRC, 1'b1, {1'b0, scss_pkg::SRC_SLOW, 4'h2});
        wait_irq();
        chk("irq", 1'b1, irq);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_SLOW, 4'h2});
        wb_rd(scss_pkg::IDX_SW_CTL, 8'h18);
        wb_cyc(scss_pkg::IDX_IRQ_STAT, 1'b1, 8'h01);
        @(posedge clk);
        chk("irq_cleared", 1'b0, irq);
        $display("test software_switch done");
        wb_cyc(scss_pkg::IDX_IRQ_MASK, 1'b1, 8'h02);
        wb_cyc(scss_pkg::IDX_NEW_SRC, 1'b1, {1'b0, scss_pkg::SRC_EXT, scss_pkg::DIV_1});
        repeat (30) @(posedge clk);
        run <= 1'b0;
        wait_irq();
        chk("fail_irq", 1'b1, irq);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_FAST, scss_pkg::DIV_1});
        wb_rd(scss_pkg::IDX_IRQ_STAT, 8'h03);
        $display("test fail_safe done");
        do_reset(scss_pkg::CH_EXT, scss_pkg::EK_XT, 1'b1, 1'b0);
        run <= 1'b1;
        chk("drive_oe_xtal", 1'b1, drv_oe);
        chk("quarter_clock_out_pin_oe_xtal", 1'b0, qout_oe);
        n = 0;
        repeat (16) @(posedge clk) n += (tick === 1'b1);
        chk("no_tick_before_startup", 1'b1, n == 0);
        repeat (80) @(posedge clk) n += (tick === 1'b1);
        chk("ticks_after_startup", 1'b1, n > 0);
        chk("quarter_clock_out_pin_xtal", 1'b0, qout);
        wb_cyc(scss_pkg::IDX_NEW_SRC, 1'b1, {1'b0, scss_pkg::SRC_FAST, scss_pkg::DIV_1});
        repeat (20) @(posedge clk);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_EXT, scss_pkg::DIV_1});
        run <= 1'b0;
        repeat (60) @(posedge clk);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_EXT, scss_pkg::DIV_1});
        $display("test crystal_and_disables done");
        do_reset(scss_pkg::CH_FAST1M, 3'h0, 1'b0, 1'b1);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_FAST, scss_pkg::DIV_1M});
        do_reset(scss_pkg::CH_SLOW, 3'h0, 1'b0, 1'b1);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_SLOW, scss_pkg::DIV_1});
        do_reset(scss_pkg::CH_FAST32, 3'h0, 1'b0, 1'b1);
        wb_rd(scss_pkg::IDX_CUR_SRC, {1'b0, scss_pkg::SRC_FAST, scss_pkg::DIV_1});
        $display("test reset_choices done");
        // Let the read monitor take the last answer first
        @(posedge clk);
        wrap_up();
    end
endmodule
